/* File: rtl/mmw_dev.sv */
// Module side two-wire write slave with timed programming cycle
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Write opens with 1010000x address, then memory address
// [RULE_02] Acknowledge memory address, then take first data
// [RULE_03] Acknowledge every complete data word
// [RULE_04] Host ends single write with STOP
// [RULE_05] Repeated START instead of STOP aborts, discards data
// [RULE_06] Valid STOP starts timed programming cycle
// [RULE_07] Bus ignored during programming cycle
// [RULE_08] Chained repeated START not supported for writes
// [RULE_09] Accept bursts up to eight data bytes
// [RULE_10] Host sends at most seven further words
// [RULE_11] Acknowledge each burst data word
// [RULE_12] Non-STOP burst ending aborts and discards data
// [RULE_13] Host polls with START and device address
// [RULE_14] Acknowledge poll only after cycle completes
// [RULE_15] Aborted dummy write keeps loaded address
// [RULE_16] Burst bytes go to consecutive addresses
// [RULE_17] Programming cycle length is a parameter
module mmw_dev #(
	parameter int WRITE_CYCLES = mmw_pkg::MMW_WRITE_CYCLE_CYCLES,
	parameter int BURST_MAX = mmw_pkg::MMW_BURST_MAX
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Bus
	mmw_if.dev BUS,
	// Memory write port, one pulse per committed byte
	output logic MEM_WE,
	output mmw_pkg::mmw_byte_t MEM_ADDR,
	output mmw_pkg::mmw_byte_t MEM_DATA,
	// Status
	output logic BUSY,
	output mmw_pkg::mmw_byte_t ADDR_PTR
);
	import mmw_pkg::*;
	// Refuse sizes the engine cannot serve: every held byte must commit inside the cycle
	if (WRITE_CYCLES < BURST_MAX || BURST_MAX < 1 || BURST_MAX > 8) begin
		$error("mmw_dev bad parameters");
	end

	typedef enum logic [5:0] {
		S_IDLE = 6'b00_0001,
		S_RECV = 6'b00_0010,
		S_ACK = 6'b00_0100,
		S_SKIP = 6'b00_1000,
		S_PROG = 6'b01_0000,
		S_END = 6'b10_0000
	} mmw_dst_t;

	// Two flop synchronisers for the pins
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= BUS.scl;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= BUS.sda;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end
	wire scl_rise = scl_s && !scl_d;
	wire scl_fall = !scl_s && scl_d;
	wire start_c = scl_s && scl_d && sda_d && !sda_s;
	wire stop_c = scl_s && scl_d && !sda_d && sda_s;

	mmw_dst_t state, next_state;
	logic [2:0] bitn, next_bitn;
	mmw_byte_t shreg, next_shreg;
	logic [1:0] phase, next_phase; // 0 dev addr, 1 mem addr, 2 data
	mmw_byte_t ptr, next_ptr;
	mmw_byte_t buf_q [BURST_MAX];
	mmw_byte_t next_buf [BURST_MAX];
	logic [3:0] cnt, next_cnt;
	logic [3:0] wi, next_wi;
	mmw_byte_t base, next_base;
	logic [31:0] timer, next_timer;
	logic ack_drv, next_ack_drv;
	logic we, next_we;
	mmw_byte_t waddr, next_waddr, wdata, next_wdata;

	// Next state of the protocol engine
	always_comb begin
		next_state = state;
		next_bitn = bitn;
		next_shreg = shreg;
		next_phase = phase;
		next_ptr = ptr;
		next_buf = buf_q;
		next_cnt = cnt;
		next_wi = wi;
		next_base = base;
		next_timer = timer;
		next_ack_drv = ack_drv;
		next_we = 1'b0;
		next_waddr = waddr;
		next_wdata = wdata;
		if (state == S_PROG) begin
			// Pins are not looked at while programming
			next_ack_drv = 1'b0; // RULE_07
			if (wi < cnt) begin
				next_we = 1'b1;
				next_waddr = 8'(base + 8'(wi)); // RULE_16
				next_wdata = buf_q[wi[2:0]];
				next_wi = 4'(wi + 4'h1);
			end
			if (timer <= 32'h0000_0001) begin
				next_state = S_IDLE; // RULE_14
				next_timer = 32'h0000_0000;
			end else begin
				next_timer = timer - 32'h0000_0001; // RULE_06 RULE_17
			end
		end else if (start_c) begin
			// Repeated START drops any held data and keeps the pointer
			next_state = S_RECV; // RULE_05 RULE_08 RULE_12 RULE_15
			next_bitn = 3'h0;
			next_phase = 2'h0;
			next_cnt = 4'h0;
			next_ack_drv = 1'b0;
		end else if (stop_c) begin
			next_ack_drv = 1'b0;
			// A STOP closes the transfer, so a later STOP cannot re-arm an old commit
			next_phase = 2'h0;
			if (phase == 2'h2 && cnt != 4'h0) begin
				next_state = S_PROG; // RULE_04 RULE_06
				next_timer = 32'(WRITE_CYCLES);
				next_wi = 4'h0;
				next_ptr = 8'(base + 8'(cnt));
			end else begin
				next_state = S_IDLE;
			end
		end else begin
			unique case (state)
				S_IDLE, S_SKIP, S_PROG: begin
				end
				S_RECV: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_s};
						next_bitn = 3'(bitn + 3'h1);
						if (bitn == 3'h7) next_state = S_END;
					end
				end
				S_END: begin
					// Decide the acknowledge on the falling edge after bit eight
					if (scl_fall) begin
						next_state = S_ACK;
						next_ack_drv = 1'b1;
						unique case (phase)
							2'h0: begin
								if ((shreg[7:1] == MMW_DEV_ADDR_A || shreg[7:1] == MMW_DEV_ADDR_B) && !shreg[0]) begin
									next_phase = 2'h1; // RULE_01
								end else begin
									next_state = S_SKIP;
									next_ack_drv = 1'b0;
								end
							end
							2'h1: begin
								next_ptr = shreg;
								next_base = shreg;
								next_phase = 2'h2; // RULE_02
							end
							default: begin
								if (cnt < 4'(BURST_MAX)) begin
									next_buf[cnt[2:0]] = shreg; // RULE_09
									next_cnt = 4'(cnt + 4'h1);
								end
								// RULE_03 RULE_11
							end
						endcase
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						next_ack_drv = 1'b0;
						next_state = S_RECV;
						next_bitn = 3'h0;
					end
				end
				default: next_state = S_IDLE;
			endcase
		end
	end

	// Register the engine
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state <= S_IDLE;
			bitn <= 3'h0;
			shreg <= 8'h00;
			phase <= 2'h0;
			ptr <= 8'h00;
			for (int i = 0; i < BURST_MAX; i++) buf_q[i] <= 8'h00;
			cnt <= 4'h0;
			wi <= 4'h0;
			base <= 8'h00;
			timer <= 32'h0000_0000;
			ack_drv <= 1'b0;
			we <= 1'b0;
			waddr <= 8'h00;
			wdata <= 8'h00;
		end else begin
			state <= next_state;
			bitn <= next_bitn;
			shreg <= next_shreg;
			phase <= next_phase;
			ptr <= next_ptr;
			buf_q <= next_buf;
			cnt <= next_cnt;
			wi <= next_wi;
			base <= next_base;
			timer <= next_timer;
			ack_drv <= next_ack_drv;
			we <= next_we;
			waddr <= next_waddr;
			wdata <= next_wdata;
		end
	end

	// Acknowledge pulls the data line low
	assign BUS.sda_dev_o = 1'b0;
	assign BUS.sda_dev_oe = ack_drv;
	assign MEM_WE = we;
	assign MEM_ADDR = waddr;
	assign MEM_DATA = wdata;
	assign BUSY = (state == S_PROG);
	assign ADDR_PTR = ptr;
endmodule

/* File: rtl/mmw_pkg.sv */
// Shared constants and types for the module management write link
package mmw_pkg;
	localparam logic [6:0] MMW_DEV_ADDR_A = 7'h50;
	localparam logic [6:0] MMW_DEV_ADDR_B = 7'h51;
	localparam int MMW_BURST_MAX = 8;
	localparam int MMW_CLK_PERIOD_PS = 4000;
	localparam int MMW_WRITE_CYCLE_TIME_NS = 5000;
	localparam int MMW_WRITE_CYCLE_CYCLES = (MMW_WRITE_CYCLE_TIME_NS * 1000) / MMW_CLK_PERIOD_PS;
	localparam int MMW_SCL_HALF = 20;
	typedef logic [7:0] mmw_byte_t;
endpackage

/* File: rtl/mmw_if.sv */
// Two-wire bus between host master and module slave
`timescale 1ns/1ps
interface mmw_if;
	logic scl_o;
	logic scl_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	// Open drain resolution with pull-ups
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
	modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe, output sda_host_o, output sda_host_oe);
endinterface

/* File: rtl/mmw_host.sv */
// Host side two-wire master issuing writes and acknowledge polls
`timescale 1ns/1ps
module mmw_host #(
	parameter int HALF = mmw_pkg::MMW_SCL_HALF
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Bus
	mmw_if.host BUS,
	// Command: POLL sends only the address; LEN is data bytes 1..8
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_POLL,
	input wire logic REQ_SEL,
	input wire mmw_pkg::mmw_byte_t REQ_MADDR,
	input wire logic [3:0] REQ_LEN,
	input wire logic [63:0] REQ_DATA,
	// Result
	output logic DONE,
	output logic ACKED
);
	import mmw_pkg::*;
	// Refuse half periods the 16 bit divider cannot count
	if (HALF < 4 || HALF > 65536) begin
		$error("mmw_host HALF out of range");
	end

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_BITS = 4'b0100,
		H_STOP = 4'b1000
	} mmw_hst_t;

	// Sample data line twice, it comes back through the pads
	logic sda_m, sda_s;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			sda_m <= BUS.sda;
			sda_s <= sda_m;
		end
	end

	mmw_hst_t state, next_state;
	logic [15:0] div, next_div;
	logic [1:0] q, next_q; // quarter of bit: 0 low, 1 low, 2 high, 3 high
	logic [3:0] bitn, next_bitn;
	logic [3:0] byten, next_byten, nbytes, next_nbytes;
	logic [79:0] frame, next_frame;
	logic scl, next_scl, sda, next_sda, ok, next_ok, done, next_done;
	wire tick = (div == 16'(HALF - 1));

	// Next state of the master: each byte is 8 data bits then the acknowledge slot
	always_comb begin
		next_state = state;
		next_div = tick ? 16'h0000 : 16'(div + 16'h0001);
		next_q = q;
		next_bitn = bitn;
		next_byten = byten;
		next_nbytes = nbytes;
		next_frame = frame;
		next_scl = scl;
		next_sda = sda;
		next_ok = ok;
		next_done = 1'b0;
		unique case (state)
			H_IDLE: begin
				next_scl = 1'b1;
				next_sda = 1'b1;
				next_div = 16'h0000;
				if (REQ_VALID) begin
					next_frame = {(REQ_SEL ? MMW_DEV_ADDR_B : MMW_DEV_ADDR_A), 1'b0, REQ_MADDR, REQ_DATA}; // RULE_01
					// Over-long requests are cut to a full burst rather than overrun the slave
					if (REQ_POLL) begin
						next_nbytes = 4'h1; // RULE_13
					end else if (REQ_LEN > 4'(MMW_BURST_MAX)) begin
						next_nbytes = 4'(MMW_BURST_MAX + 2); // RULE_10
					end else begin
						next_nbytes = 4'(REQ_LEN + 4'h2);
					end
					next_state = H_START;
					next_q = 2'h0;
					next_ok = 1'b1;
				end
			end
			H_START: begin
				if (tick) begin
					next_q = 2'(q + 2'h1);
					if (q == 2'h0) next_sda = 1'b0;
					if (q == 2'h1) begin
						next_scl = 1'b0;
						next_state = H_BITS;
						next_q = 2'h0;
						next_bitn = 4'h0;
						next_byten = 4'h0;
					end
				end
			end
			H_BITS: begin
				if (tick) begin
					next_q = 2'(q + 2'h1);
					if (q == 2'h0) next_sda = (bitn == 4'h8) ? 1'b1 : frame[79];
					if (q == 2'h1) next_scl = 1'b1;
					if (q == 2'h2 && bitn == 4'h8 && sda_s) next_ok = 1'b0;
					if (q == 2'h3) begin
						next_scl = 1'b0;
						if (bitn == 4'h8) begin
							next_bitn = 4'h0;
							next_byten = 4'(byten + 4'h1);
							if (byten + 4'h1 == nbytes || !ok) next_state = H_STOP;
						end else begin
							next_bitn = 4'(bitn + 4'h1);
							next_frame = {frame[78:0], 1'b0};
						end
					end
				end
			end
			H_STOP: begin
				if (tick) begin
					next_q = 2'(q + 2'h1);
					if (q == 2'h0) next_sda = 1'b0;
					if (q == 2'h1) next_scl = 1'b1;
					if (q == 2'h2) next_sda = 1'b1; // RULE_04 RULE_12
					if (q == 2'h3) begin
						next_state = H_IDLE;
						next_done = 1'b1;
					end
				end
			end
			default: next_state = H_IDLE;
		endcase
	end

	// Register the master
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state <= H_IDLE;
			div <= 16'h0000;
			q <= 2'h0;
			bitn <= 4'h0;
			byten <= 4'h0;
			nbytes <= 4'h0;
			frame <= 80'h0;
			scl <= 1'b1;
			sda <= 1'b1;
			ok <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			div <= next_div;
			q <= next_q;
			bitn <= next_bitn;
			byten <= next_byten;
			nbytes <= next_nbytes;
			frame <= next_frame;
			scl <= next_scl;
			sda <= next_sda;
			ok <= next_ok;
			done <= next_done;
		end
	end

	// Open drain outputs: drive only lows
	assign BUS.scl_o = 1'b0;
	assign BUS.scl_oe = !scl;
	assign BUS.sda_host_o = 1'b0;
	assign BUS.sda_host_oe = !sda;
	assign REQ_READY = (state == H_IDLE);
	assign DONE = done;
	assign ACKED = ok;
endmodule

/* File: bench/mmw_props.sv */
// Checker for the two-wire write link between host and module ends
`timescale 1ns/1ps
module mmw_props #(
	parameter int WRITE_CYCLES = 50
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Wire levels and device drive
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe,
	// Device status
	input wire logic BUSY,
	input wire logic MEM_WE
);
	int busy_cnt;
	int next_busy_cnt;
	// Length of the current busy run, judged at the cycle it ends
	always_comb begin
		next_busy_cnt = BUSY ? busy_cnt + 1 : 0;
	end
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= next_busy_cnt;
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	busy_quiet_a: assert property (BUSY |-> !sda_dev_oe)
		else $error("device drives sda while busy");
	cycle_len_a: assert property ($fell(BUSY) |-> busy_cnt == WRITE_CYCLES)
		else $error("programming cycle length wrong");
	cycle_idle_a: assert property ($rose(BUSY) |-> scl && sda)
		else $error("programming began on a busy bus");
	ack_rise_a: assert property ($rose(sda_dev_oe) |-> !scl)
		else $error("acknowledge raised while scl high");
	ack_fall_a: assert property ($fell(sda_dev_oe) |-> !scl)
		else $error("acknowledge dropped while scl high");
	ack_hold_a: assert property (sda_dev_oe && scl |=> sda_dev_oe)
		else $error("acknowledge not held over scl high");
	ack_width_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
		else $error("acknowledge too short");
	commit_busy_a: assert property (MEM_WE |-> $past(BUSY))
		else $error("byte committed outside a programming cycle");
	// Main scenarios reached
	cover property ($rose(BUSY));
	cover property ($fell(BUSY));
	cover property (MEM_WE);
	cover property ($rose(sda_dev_oe));
endmodule

/* File: bench/mmw_tb_top.sv */
// Testbench joining host and module ends, plus a rule breaking driver on a second link
`timescale 1ns/1ps
module mmw_tb_top;
	import mmw_pkg::*;
	// Long enough that the first poll lands inside the cycle
	localparam int WCYC = 2000;
	logic clock, rst, req_valid, req_ready, req_poll, req_sel, done, acked, mem_we, busy, we2, busy2, a;
	logic [3:0] req_len;
	logic [63:0] req_data;
	mmw_byte_t req_maddr, mem_addr, mem_data, ptr1, ptr2;
	mmw_byte_t mem [256];
	int wcnt, wcnt2, miscompares, total_checks;
	mmw_if mmw_if_i ();
	mmw_if mmw_if_i2 ();
	mmw_host #(.HALF(MMW_SCL_HALF)) mmw_host_i (.CLOCK(clock), .RST(rst), .BUS(mmw_if_i),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_POLL(req_poll), .REQ_SEL(req_sel),
		.REQ_MADDR(req_maddr), .REQ_LEN(req_len), .REQ_DATA(req_data), .DONE(done), .ACKED(acked));
	mmw_dev #(.WRITE_CYCLES(WCYC), .BURST_MAX(MMW_BURST_MAX)) mmw_dev_i (.CLOCK(clock), .RST(rst),
		.BUS(mmw_if_i), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .BUSY(busy), .ADDR_PTR(ptr1));
	mmw_dev #(.WRITE_CYCLES(WCYC), .BURST_MAX(MMW_BURST_MAX)) mmw_dev_i2 (.CLOCK(clock), .RST(rst),
		.BUS(mmw_if_i2), .MEM_WE(we2), .MEM_ADDR(), .MEM_DATA(), .BUSY(busy2), .ADDR_PTR(ptr2));
	mmw_props #(.WRITE_CYCLES(WCYC)) mmw_props_i (.CLOCK(clock), .RST(rst), .scl(mmw_if_i.scl),
		.sda(mmw_if_i.sda), .sda_dev_oe(mmw_if_i.sda_dev_oe), .BUSY(busy), .MEM_WE(mem_we));
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	// Memory image built from the commit port
	always @(posedge clock) begin
		if (mem_we === 1'b1) begin
			mem[mem_addr] <= mem_data;
			wcnt <= wcnt + 1;
		end
		if (we2 === 1'b1) begin
			wcnt2 <= wcnt2 + 1;
		end
	end
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One host request, held across the edge that takes it, then a bounded wait for the end
	task xfer(input logic poll, input logic sel, input mmw_byte_t ma, input logic [3:0] len, input logic [63:0] d);
		int n;
		n = 0;
		@(negedge clock);
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		{req_poll, req_sel, req_maddr, req_len, req_data} = {poll, sel, ma, len, d};
		req_valid = 1;
		@(negedge clock);
		req_valid = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(negedge clock);
			n++;
		end
		if (done !== 1'b1) begin
			miscompares++;
			end_of_test;
		end
	endtask
	task poll_wait;
		int k;
		k = 0;
		xfer(1, 0, 8'h00, 4'h1, 64'h0);
		while (acked !== 1'b1 && k < 30) begin
			xfer(1, 0, 8'h00, 4'h1, 64'h0);
			k++;
		end
		chk("poll ack", acked, 1);
	endtask
	// Bit level driver for the second link; the line reads released when driven high
	task bb(input logic s, input logic c);
		mmw_if_i2.sda_host_o = s;
		mmw_if_i2.scl_o = c;
		repeat (10) @(negedge clock);
	endtask
	task bbyte(input logic [8:0] v, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			bb(v[i], 0);
			bb(v[i], 1);
			ack = !mmw_if_i2.sda;
			bb(v[i], 1);
			bb(v[i], 0);
		end
	endtask
	initial begin
		{req_valid, req_poll, req_sel, req_maddr, req_len, req_data} = '0;
		{wcnt, wcnt2, miscompares, total_checks} = '0;
		{mmw_if_i2.scl_oe, mmw_if_i2.sda_host_oe, mmw_if_i2.scl_o, mmw_if_i2.sda_host_o} = 4'hF;
		rst = 1;
		repeat (16) @(negedge clock);
		rst = 0;
		xfer(0, 0, 8'h10, 4'h1, 64'h5A00_0000_0000_0000);
		chk("write ack", acked, 1);
		xfer(1, 0, 8'h00, 4'h1, 64'h0);
		chk("busy poll", acked, 0);
		poll_wait;
		chk("busy end", busy, 0);
		chk("byte", mem[8'h10], 8'h5A);
		chk("commits", wcnt, 1);
		chk("pointer", ptr1, 8'h11);
		$display("test single write done");
		xfer(0, 1, 8'h20, 4'h8, 64'h0011_2233_4455_6677);
		chk("burst ack", acked, 1);
		poll_wait;
		for (int i = 0; i < 8; i++) chk("burst byte", mem[mmw_byte_t'(8'h20 + i)], mmw_byte_t'(8'h11 * i));
		chk("burst commits", wcnt, 9);
		chk("burst pointer", ptr1, 8'h28);
		$display("test burst write done");
		bb(0, 1);
		bb(0, 0);
		bbyte({8'hA0, 1'b1}, a);
		chk("addr ack", a, 1);
		bbyte({8'h40, 1'b1}, a);
		chk("maddr ack", a, 1);
		bbyte({8'hEE, 1'b1}, a);
		chk("data ack", a, 1);
		bbyte({8'hDD, 1'b1}, a);
		chk("burst data ack", a, 1);
		bb(1, 0);
		bb(1, 1);
		bb(0, 1);
		bb(0, 0);
		bb(0, 1);
		bb(1, 1);
		repeat (WCYC + 100) @(negedge clock);
		chk("aborted commits", wcnt2, 0);
		chk("aborted busy", busy2, 0);
		chk("kept pointer", ptr2, 8'h40);
		$display("test aborted write done");
		end_of_test;
	end
endmodule
